//--- hw/ccs_command_status.sv
// Command decoder, format fields and status flags of the raster display controller.
module ccs_command_status
   import ccs_pkg::*;
(
   input logic clk,
   input logic rst_n,
   input logic bus_wr,
   input logic bus_rd,
   input logic register_select,
   input logic [7:0] wr_data,
   output logic [7:0] rd_data,
   input logic pen_input,
   input logic [7:0] pen_char,
   input logic [7:0] pen_row,
   input logic last_row_start,
   input logic hretrace_start,
   input logic vretrace_level,
   input logic vretrace_end,
   input logic underrun_event,
   input logic overrun_event,
   output logic [7:0] controller_status,
   output logic irq_out,
   output logic horizontal_retrace_out,
   output logic vertical_retrace_out,
   output logic video_suppress_out,
   output logic dma_enable,
   output logic [2:0] burst_gap_code,
   output logic [5:0] burst_gap_clocks,
   output logic [1:0] burst_len_code,
   output logic [3:0] burst_len,
   output logic spaced_rows,
   output logic [6:0] chars_per_row_code,
   output logic [1:0] vretrace_rows_code,
   output logic [5:0] rows_per_frame_code,
   output logic [3:0] underline_line,
   output logic blank_edge_lines,
   output logic [3:0] lines_per_row_field,
   output logic [4:0] lines_per_row,
   output logic line_mode_offset,
   output logic field_attr_opaque,
   output logic [1:0] cursor_style_code,
   output logic cursor_blink,
   output logic cursor_block,
   output logic [3:0] hretrace_count_field,
   output logic [5:0] hretrace_clocks,
   output logic [7:0] cursor_char,
   output logic [7:0] cursor_row,
   output logic counter_preset,
   output logic preset_hold,
   output logic first_row_go
);

   // ***********************************************
   // Host access decode
   // ***********************************************
   logic cmd_wr;
   logic stat_rd;
   logic param_acc;
   logic param_wr;
   logic param_rd;
   ccs_cmd_t cmd_in;

   assign cmd_wr = bus_wr & register_select;
   assign stat_rd = bus_rd & register_select;
   assign param_wr = bus_wr & ~register_select;
   assign param_rd = bus_rd & ~register_select;
   assign param_acc = param_wr | param_rd;
   assign cmd_in = ccs_cmd_t'(wr_data[7:5]);

   // ***********************************************
   // State
   // ***********************************************
   ccs_cmd_t cmd_reg;
   ccs_cmd_t cmd_next;
   logic [2:0] pidx_reg;
   logic [2:0] pidx_next;
   logic ie_reg;
   logic ie_next;
   logic ve_reg;
   logic ve_next;
   logic dma_on_reg;
   logic dma_on_next;
   logic ublank_reg;
   logic ublank_next;
   logic pen_prev_reg;
   logic [7:0] pen_char_reg;
   logic [7:0] pen_char_next;
   logic [7:0] pen_row_reg;
   logic [7:0] pen_row_next;
   logic [7:0] rd_next;
   logic hold_next;
   logic preset_load;
   logic release_load;
   logic [CCS_FLAGS-1:0] flag_set;
   logic [CCS_FLAGS-1:0] flags;
   logic [2:0] need;
   logic pen_fire;
   logic [2:0] gap_code_next;
   logic [5:0] gap_clocks_next;
   logic [1:0] len_code_next;
   logic [3:0] len_next;
   logic spaced_next;
   logic [6:0] chars_next;
   logic [1:0] vrows_next;
   logic [5:0] rows_next;
   logic [3:0] uline_next;
   logic [3:0] lfield_next;
   logic [4:0] lines_next;
   logic lmode_next;
   logic fattr_next;
   logic [1:0] cstyle_next;
   logic [3:0] hfield_next;
   logic [5:0] hclocks_next;
   logic [7:0] cchar_next;
   logic [7:0] crow_next;

   assign need = ccs_param_need(cmd_reg);
   assign pen_fire = pen_input & ~pen_prev_reg;

   // ***********************************************
   // Command and parameter sequencing
   // ***********************************************
   always_comb begin
      cmd_next = cmd_reg;
      pidx_next = pidx_reg;
      ie_next = ie_reg;
      ve_next = ve_reg;
      dma_on_next = dma_on_reg;
      hold_next = preset_hold;
      preset_load = 1'b0;
      release_load = 1'b0;
      flag_set = '0;
      gap_code_next = burst_gap_code;
      gap_clocks_next = burst_gap_clocks;
      len_code_next = burst_len_code;
      len_next = burst_len;
      spaced_next = spaced_rows;
      chars_next = chars_per_row_code;
      vrows_next = vretrace_rows_code;
      rows_next = rows_per_frame_code;
      uline_next = underline_line;
      lfield_next = lines_per_row_field;
      lines_next = lines_per_row;
      lmode_next = line_mode_offset;
      fattr_next = field_attr_opaque;
      cstyle_next = cursor_style_code;
      hfield_next = hretrace_count_field;
      hclocks_next = hretrace_clocks;
      cchar_next = cursor_char;
      crow_next = cursor_row;
      if (cmd_wr) begin
         cmd_next = cmd_in;
         pidx_next = 3'h0;
         if (pidx_reg < need) begin
            flag_set[CCS_FL_IC] = 1'b1;
         end
         if (preset_hold && cmd_in != CCS_CMD_PRESET) begin
            hold_next = 1'b0;
            release_load = 1'b1;
         end
         case (cmd_in)
            CCS_CMD_RESET: begin
               ie_next = 1'b0;
               ve_next = 1'b0;
               dma_on_next = 1'b0;
            end
            CCS_CMD_START: begin
               ie_next = 1'b1;
               ve_next = 1'b1;
               dma_on_next = 1'b1;
               gap_code_next = wr_data[4:2];
               if (wr_data[4:2] == 3'h0) begin
                  gap_clocks_next = 6'h00;
               end else begin
                  gap_clocks_next = {wr_data[4:2], 3'h0} - CCS_GAP_STEP_LESS;
               end
               len_code_next = wr_data[1:0];
               len_next = 4'(4'h1 << wr_data[1:0]);
            end
            CCS_CMD_STOP: begin
               ve_next = 1'b0;
            end
            CCS_CMD_IRQ_ON: begin
               ie_next = 1'b1;
            end
            CCS_CMD_IRQ_OFF: begin
               ie_next = 1'b0;
            end
            CCS_CMD_PRESET: begin
               hold_next = 1'b1;
               preset_load = 1'b1;
            end
            default: begin
               cmd_next = cmd_in;
            end
         endcase
      end else if (param_acc) begin
         if (pidx_reg >= need) begin
            flag_set[CCS_FL_IC] = 1'b1;
         end
         if (pidx_reg != CCS_IDX_MAX) begin
            pidx_next = pidx_reg + 3'h1;
         end
         if (param_wr && cmd_reg == CCS_CMD_RESET) begin
            case (pidx_reg)
               3'h0: begin
                  spaced_next = wr_data[7];
                  chars_next = wr_data[6:0];
               end
               3'h1: begin
                  vrows_next = wr_data[7:6];
                  rows_next = wr_data[5:0];
               end
               3'h2: begin
                  uline_next = wr_data[7:4];
                  lfield_next = wr_data[3:0];
                  lines_next = {1'b0, wr_data[3:0]} + 5'h01;
               end
               3'h3: begin
                  lmode_next = wr_data[7];
                  fattr_next = wr_data[6];
                  cstyle_next = wr_data[5:4];
                  hfield_next = wr_data[3:0];
                  hclocks_next = {1'b0, wr_data[3:0], 1'b0} + CCS_HR_BASE;
               end
               default: begin
                  spaced_next = spaced_rows;
               end
            endcase
         end
         if (param_wr && cmd_reg == CCS_CMD_CURSOR) begin
            if (pidx_reg == 3'h0) begin
               cchar_next = wr_data;
            end else if (pidx_reg == 3'h1) begin
               crow_next = wr_data;
            end
         end
      end
      if (last_row_start && ie_reg) begin
         flag_set[CCS_FL_IR] = 1'b1;
      end
      if (pen_fire) begin
         flag_set[CCS_FL_LP] = 1'b1;
      end
      if (underrun_event) begin
         flag_set[CCS_FL_DU] = 1'b1;
      end
      if (overrun_event) begin
         flag_set[CCS_FL_FO] = 1'b1;
      end
   end

   // ***********************************************
   // Pen capture, underrun blanking and read data
   // ***********************************************
   always_comb begin
      pen_char_next = pen_char_reg;
      pen_row_next = pen_row_reg;
      if (pen_fire) begin
         pen_char_next = pen_char;
         pen_row_next = pen_row;
      end
      ublank_next = ublank_reg;
      if (vretrace_end) begin
         ublank_next = 1'b0;
      end
      if (underrun_event) begin
         ublank_next = 1'b1;
      end
      rd_next = rd_data;
      if (stat_rd) begin
         // Live flags are read so a flag set just before the read is reported, not cleared unseen.
         rd_next = {1'b0, ie_reg, flags[CCS_FL_IR], flags[CCS_FL_LP], flags[CCS_FL_IC],
                    ve_reg, flags[CCS_FL_DU], flags[CCS_FL_FO]};
      end else if (param_rd) begin
         rd_next = CCS_BYTE_RESET;
         if (cmd_reg == CCS_CMD_PEN && pidx_reg == 3'h0) begin
            rd_next = pen_char_reg;
         end else if (cmd_reg == CCS_CMD_PEN && pidx_reg == 3'h1) begin
            rd_next = pen_row_reg;
         end
      end
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmd_reg <= CCS_CMD_IDLE;
         pidx_reg <= 3'h0;
         ie_reg <= 1'b0;
         ve_reg <= 1'b0;
         dma_on_reg <= 1'b0;
         ublank_reg <= 1'b0;
         pen_prev_reg <= 1'b0;
         pen_char_reg <= CCS_BYTE_RESET;
         pen_row_reg <= CCS_BYTE_RESET;
         rd_data <= CCS_BYTE_RESET;
         controller_status <= CCS_BYTE_RESET;
         irq_out <= 1'b0;
         vertical_retrace_out <= 1'b0;
         video_suppress_out <= 1'b1;
         dma_enable <= 1'b0;
         preset_hold <= 1'b0;
         burst_gap_code <= 3'h0;
         burst_gap_clocks <= 6'h00;
         burst_len_code <= 2'h0;
         burst_len <= CCS_BURST_RESET;
         spaced_rows <= 1'b0;
         chars_per_row_code <= 7'h00;
         vretrace_rows_code <= 2'h0;
         rows_per_frame_code <= 6'h00;
         underline_line <= 4'h0;
         blank_edge_lines <= 1'b0;
         lines_per_row_field <= 4'h0;
         lines_per_row <= CCS_LINES_RESET;
         line_mode_offset <= 1'b0;
         field_attr_opaque <= 1'b0;
         cursor_style_code <= 2'h0;
         cursor_blink <= 1'b1;
         cursor_block <= 1'b0;
         hretrace_count_field <= 4'h0;
         hretrace_clocks <= CCS_HR_RESET;
         cursor_char <= CCS_BYTE_RESET;
         cursor_row <= CCS_BYTE_RESET;
      end else begin
         cmd_reg <= cmd_next;
         pidx_reg <= pidx_next;
         ie_reg <= ie_next;
         ve_reg <= ve_next;
         dma_on_reg <= dma_on_next;
         ublank_reg <= ublank_next;
         pen_prev_reg <= pen_input;
         pen_char_reg <= pen_char_next;
         pen_row_reg <= pen_row_next;
         rd_data <= rd_next;
         // Status mirrors the flags one clock later; a status read returns the live flags, not this copy.
         controller_status <= {1'b0, ie_next, flags[CCS_FL_IR], flags[CCS_FL_LP],
                               flags[CCS_FL_IC], ve_next, flags[CCS_FL_DU],
                               flags[CCS_FL_FO]};
         irq_out <= flags[CCS_FL_IR];
         vertical_retrace_out <= vretrace_level;
         video_suppress_out <= ~ve_next | ublank_next;
         dma_enable <= dma_on_next & ~ublank_next;
         preset_hold <= hold_next;
         burst_gap_code <= gap_code_next;
         burst_gap_clocks <= gap_clocks_next;
         burst_len_code <= len_code_next;
         burst_len <= len_next;
         spaced_rows <= spaced_next;
         chars_per_row_code <= chars_next;
         vretrace_rows_code <= vrows_next;
         rows_per_frame_code <= rows_next;
         underline_line <= uline_next;
         blank_edge_lines <= uline_next[3];
         lines_per_row_field <= lfield_next;
         lines_per_row <= lines_next;
         line_mode_offset <= lmode_next;
         field_attr_opaque <= fattr_next;
         cursor_style_code <= cstyle_next;
         cursor_blink <= ~cstyle_next[1];
         cursor_block <= ~cstyle_next[0];
         hretrace_count_field <= hfield_next;
         hretrace_clocks <= hclocks_next;
         cursor_char <= cchar_next;
         cursor_row <= crow_next;
      end
   end

   // ***********************************************
   // Sticky flags and timers
   // ***********************************************
   ccs_sticky #(
      .N(CCS_FLAGS)
   ) u_flags (
      .clk(clk),
      .rst_n(rst_n),
      .set(flag_set),
      .clear(stat_rd),
      .flags(flags)
   );

   // Retrace keeps running through reset and stop commands.
   ccs_delay #(
      .W(6)
   ) u_hretrace (
      .clk(clk),
      .rst_n(rst_n),
      .load(hretrace_start),
      .count(hretrace_clocks),
      .busy(horizontal_retrace_out),
      .done()
   );

   ccs_delay #(
      .W(6)
   ) u_preset (
      .clk(clk),
      .rst_n(rst_n),
      .load(preset_load),
      .count(CCS_PRESET_CLOCKS),
      .busy(counter_preset),
      .done()
   );

   ccs_delay #(
      .W(6)
   ) u_release (
      .clk(clk),
      .rst_n(rst_n),
      .load(release_load),
      .count(CCS_RELEASE_CLOCKS),
      .busy(),
      .done(first_row_go)
   );

endmodule // ccs_command_status

//--- hw/ccs_pkg.sv
// Shared constants, command codes and field layout of the command and status unit.
package ccs_pkg;

   // ***********************************************
   // Command codes in the top three bits of a command byte
   // ***********************************************
   typedef enum logic [2:0] {
      CCS_CMD_RESET = 3'b000,
      CCS_CMD_START = 3'b001,
      CCS_CMD_STOP = 3'b010,
      CCS_CMD_PEN = 3'b011,
      CCS_CMD_CURSOR = 3'b100,
      CCS_CMD_IRQ_ON = 3'b101,
      CCS_CMD_IRQ_OFF = 3'b110,
      CCS_CMD_PRESET = 3'b111
   } ccs_cmd_t;

   // ***********************************************
   // Parameter byte counts per command
   // ***********************************************
   localparam logic [2:0] CCS_NEED_RESET = 3'h4;
   localparam logic [2:0] CCS_NEED_PAIR = 3'h2;
   localparam logic [2:0] CCS_NEED_NONE = 3'h0;
   localparam logic [2:0] CCS_IDX_MAX = 3'h7;

   // ***********************************************
   // Status byte bit positions and sticky flag indices
   // ***********************************************
   localparam int CCS_ST_IE = 6;
   localparam int CCS_ST_VE = 2;
   localparam int CCS_FLAGS = 5;
   localparam int CCS_FL_IR = 4;
   localparam int CCS_FL_LP = 3;
   localparam int CCS_FL_IC = 2;
   localparam int CCS_FL_DU = 1;
   localparam int CCS_FL_FO = 0;

   // ***********************************************
   // Timing counts in character clocks
   // ***********************************************
   localparam logic [5:0] CCS_PRESET_CLOCKS = 6'h02;
   localparam logic [5:0] CCS_RELEASE_CLOCKS = 6'h02;
   localparam logic [5:0] CCS_HR_BASE = 6'h02;
   localparam logic [5:0] CCS_GAP_STEP_LESS = 6'h01;

   // ***********************************************
   // Values after reset
   // ***********************************************
   localparam logic [7:0] CCS_BYTE_RESET = 8'h00;
   localparam logic [4:0] CCS_LINES_RESET = 5'h01;
   localparam logic [5:0] CCS_HR_RESET = 6'h02;
   localparam logic [3:0] CCS_BURST_RESET = 4'h1;
   localparam ccs_cmd_t CCS_CMD_IDLE = CCS_CMD_START;

   // Returns how many parameter bytes a command expects.
   function automatic logic [2:0] ccs_param_need(input ccs_cmd_t cmd);
      case (cmd)
         CCS_CMD_RESET: ccs_param_need = CCS_NEED_RESET;
         CCS_CMD_PEN: ccs_param_need = CCS_NEED_PAIR;
         CCS_CMD_CURSOR: ccs_param_need = CCS_NEED_PAIR;
         default: ccs_param_need = CCS_NEED_NONE;
      endcase
   endfunction

endpackage

//--- hw/ccs_delay.sv
// Loadable down counter that stays busy for a given number of clocks.
module ccs_delay #(
   parameter int W = 6
) (
   input logic clk,
   input logic rst_n,
   input logic load,
   input logic [W-1:0] count,
   output logic busy,
   output logic done
);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic busy_next;
   logic done_next;

   always_comb begin
      count_next = count_reg;
      busy_next = 1'b0;
      done_next = 1'b0;
      if (load) begin
         count_next = count;
         busy_next = (count != '0);
      end else if (count_reg != '0) begin
         count_next = count_reg - 1'b1;
         busy_next = (count_reg > 1);
         done_next = (count_reg == 1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count_reg <= count_next;
         busy <= busy_next;
         done <= done_next;
      end
   end

endmodule // ccs_delay

//--- hw/ccs_sticky.sv
// Bank of sticky flags that hardware sets and a status read clears.
module ccs_sticky #(
   parameter int N = 5
) (
   input logic clk,
   input logic rst_n,
   input logic [N-1:0] set,
   input logic clear,
   output logic [N-1:0] flags
);

   logic [N-1:0] flags_next;

   // A set in the clearing cycle is kept.
   always_comb begin
      flags_next = (clear ? '0 : flags) | set;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= flags_next;
      end
   end

endmodule // ccs_sticky

//--- verification/ccs_command_status_sva.sv
// Assertions on the ports of the command and status unit.
module ccs_command_status_sva (
   input logic clk,
   input logic rst_n,
   input logic bus_wr,
   input logic register_select,
   input logic [7:0] wr_data,
   input logic hretrace_start,
   input logic underrun_event,
   input logic [7:0] controller_status,
   input logic horizontal_retrace_out,
   input logic [3:0] hretrace_count_field,
   input logic [5:0] hretrace_clocks,
   input logic [3:0] lines_per_row_field,
   input logic [4:0] lines_per_row,
   input logic [2:0] burst_gap_code,
   input logic [5:0] burst_gap_clocks,
   input logic video_suppress_out,
   input logic dma_enable,
   input logic counter_preset,
   input logic preset_hold,
   input logic first_row_go
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic cmd;
   assign cmd = bus_wr && register_select;
   a_rows_plus_one: assert property (lines_per_row == lines_per_row_field + 5'h1)
      else $error("lines per row wrong");
   a_retrace_span: assert property (hretrace_clocks == {1'b0, hretrace_count_field, 1'b0} + 6'h2)
      else $error("retrace span wrong");
   a_retrace_run: assert property (hretrace_start |=> horizontal_retrace_out [*2])
      else $error("retrace too short");
   a_gap_map: assert property (burst_gap_clocks == ((burst_gap_code == 3'h0) ? 6'h0 :
      {burst_gap_code, 3'h0} - 6'h1))
      else $error("burst gap wrong");
   a_start_flags: assert property (cmd && wr_data[7:5] == 3'h1 |=>
      controller_status[6] && controller_status[2])
      else $error("start flags missing");
   a_stop_blank: assert property (cmd && wr_data[7:5] == 3'h2 |=>
      !controller_status[2] && video_suppress_out)
      else $error("stop did not blank");
   a_preset_pair: assert property (cmd && wr_data[7:5] == 3'h7 |=> counter_preset [*2])
      else $error("preset not two clocks");
   a_release_go: assert property (preset_hold && cmd && wr_data[7:5] != 3'h7 |=>
      !preset_hold ##2 first_row_go)
      else $error("first row late");
   a_underrun_stop: assert property (underrun_event |=> !dma_enable && video_suppress_out)
      else $error("underrun not stopped");
endmodule // ccs_command_status_sva

bind ccs_command_status ccs_command_status_sva i_ccs_command_status_sva (.*);

//--- verification/ccs_raster_model.sv
// Raster timing model feeding retrace and frame events to the unit.
module ccs_raster_model (
   input logic clk,
   input logic rst_n,
   input logic frame,
   output logic last_row_start,
   output logic hretrace_start,
   output logic vretrace_level,
   output logic vretrace_end
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] h_reg;
   logic [3:0] v_reg;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         h_reg <= 6'h00;
         v_reg <= 4'h0;
         last_row_start <= 1'b0;
         vretrace_end <= 1'b0;
      end else begin
         h_reg <= h_reg + 6'h01;
         last_row_start <= frame;
         if (last_row_start) begin
            v_reg <= 4'hf;
         end else if (v_reg != 4'h0) begin
            v_reg <= v_reg - 4'h1;
         end
         vretrace_end <= (v_reg == 4'h1);
      end
   end
   assign hretrace_start = (h_reg == 6'h3f);
   assign vretrace_level = (v_reg != 4'h0);
endmodule // ccs_raster_model

//--- verification/tb_ccs_command_status.sv
// Self-checking testbench of the command and status unit.
module tb_ccs_command_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, bus_wr, bus_rd, register_select, pen_input, last_row_start;
   logic hretrace_start, vretrace_level, vretrace_end, underrun_event, overrun_event;
   logic irq_out, horizontal_retrace_out, vertical_retrace_out, video_suppress_out;
   logic dma_enable, spaced_rows, blank_edge_lines, line_mode_offset, field_attr_opaque;
   logic cursor_blink, cursor_block, counter_preset, preset_hold, first_row_go, frame;
   logic [7:0] wr_data, rd_data, pen_char, pen_row, controller_status, cursor_char, cursor_row;
   logic [6:0] chars_per_row_code;
   logic [5:0] burst_gap_clocks, rows_per_frame_code, hretrace_clocks;
   logic [4:0] lines_per_row;
   logic [3:0] burst_len, underline_line, lines_per_row_field, hretrace_count_field;
   logic [2:0] burst_gap_code;
   logic [1:0] burst_len_code, vretrace_rows_code, cursor_style_code;
   logic [31:0] seed = 32'h0000_0042;
   logic [7:0] b [4];
   logic [7:0] q;
   int failures = 0;
   int num_checks = 0;
   ccs_command_status i_ccs_command_status (.*);
   ccs_raster_model i_ccs_raster_model (.*);
   always #12.5 clk = ~clk;
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [7:0] gap_exp(input logic [2:0] c);
      return (c == 3'h0) ? 8'h00 : {2'h0, c, 3'h0} - 8'h01;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      register_select <= sel;
      wr_data <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic sel);
      @(posedge clk);
      bus_rd <= 1'b1;
      register_select <= sel;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(posedge clk);
      #1;
      q = rd_data;
   endtask
   task automatic frame_go();
      @(posedge clk);
      frame <= 1'b1;
      @(posedge clk);
      frame <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
   initial begin
      {clk, rst_n, bus_wr, bus_rd, register_select, pen_input, frame} = '0;
      {underrun_event, overrun_event, wr_data, pen_char, pen_row} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(controller_status, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(1'b1, 8'h20);
         wr(1'b1, 8'h00);
         foreach (b[k]) b[k] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
         foreach (b[k]) wr(1'b0, b[k]);
         chk(8'(lines_per_row), 8'(b[2][3:0]) + 8'h01);
         chk(8'(hretrace_clocks), {3'h0, b[3][3:0], 1'b0} + 8'h02);
         chk(8'({line_mode_offset, field_attr_opaque, blank_edge_lines, cursor_blink,
            cursor_block}), 8'({b[3][7], b[3][6], b[2][7], !b[3][5], !b[3][4]}));
         chk({chars_per_row_code, spaced_rows}, {b[0][6:0], b[0][7]});
         chk({vretrace_rows_code, rows_per_frame_code}, b[1]);
         chk({underline_line, lines_per_row_field}, b[2]);
         chk({cursor_style_code, 2'h0, hretrace_count_field}, {b[3][5:4], 2'h0, b[3][3:0]});
         chk(8'({controller_status[6], controller_status[2], dma_enable, video_suppress_out}),
            8'h01);
      end
      for (int c = 0; c < 32; c++) begin
         wr(1'b1, 8'h20 | 8'(c));
         chk(8'(burst_gap_clocks), gap_exp(3'(c >> 2)));
         chk(8'(burst_len), 8'h01 << c[1:0]);
         chk(8'({burst_gap_code, burst_len_code}), 8'(c));
         chk(8'({controller_status[6], controller_status[2], dma_enable, video_suppress_out}),
            8'h0e);
      end
      wr(1'b1, 8'h40);
      chk(8'({controller_status[6], controller_status[2], video_suppress_out}), 8'h05);
      wr(1'b1, 8'hc0);
      frame_go();
      chk(8'({irq_out, vertical_retrace_out}), 8'h01);
      rd(1'b1);
      chk(q & 8'h60, 8'h00);
      wr(1'b1, 8'ha0);
      frame_go();
      chk(8'({irq_out, vertical_retrace_out}), 8'h03);
      rd(1'b1);
      chk(q & 8'h60, 8'h60);
      rd(1'b1);
      chk(q & 8'h20, 8'h00);
      chk(8'(irq_out), 8'h00);
      wr(1'b1, 8'h20);
      b[0] = rnd();
      b[1] = rnd();
      @(posedge clk);
      {pen_char, pen_row, pen_input} <= {b[0], b[1], 1'b1};
      @(posedge clk);
      {pen_char, pen_row, pen_input} <= {~b[0], ~b[1], 1'b0};
      wr(1'b1, 8'h60);
      rd(1'b0);
      chk(q, b[0]);
      rd(1'b0);
      chk(q, b[1]);
      rd(1'b1);
      chk(q & 8'h18, 8'h10);
      wr(1'b1, 8'h80);
      wr(1'b0, b[1]);
      wr(1'b0, b[0]);
      chk(cursor_char ^ cursor_row, b[1] ^ b[0]);
      chk(cursor_char, b[1]);
      wr(1'b1, 8'h80);
      wr(1'b0, b[0]);
      wr(1'b1, 8'ha0);
      rd(1'b1);
      chk(q & 8'h08, 8'h08);
      wr(1'b0, b[0]);
      rd(1'b1);
      chk(q & 8'h08, 8'h08);
      @(posedge clk);
      {underrun_event, overrun_event} <= 2'b11;
      @(posedge clk);
      {underrun_event, overrun_event} <= 2'b00;
      rd(1'b1);
      chk(q & 8'h0f, 8'h07);
      chk(8'({dma_enable, video_suppress_out}), 8'h01);
      frame_go();
      repeat (20) @(posedge clk);
      #1;
      chk(8'(video_suppress_out), 8'h00);
      rd(1'b1);
      chk(q & 8'h03, 8'h00);
      wr(1'b1, 8'he0);
      chk(8'({preset_hold, counter_preset}), 8'h03);
      wr(1'b1, 8'h20);
      @(posedge clk);
      #1;
      chk(8'({preset_hold, first_row_go}), 8'h00);
      @(posedge clk);
      #1;
      chk(8'(first_row_go), 8'h01);
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule // tb_ccs_command_status
